// ==== rsc_pkg.sv ====
package rsc_pkg;
	// --------------------------------------------------------------
	// Source and flag layout
	// --------------------------------------------------------------
	localparam int NUM_SRC = 9;
	localparam int NUM_FLAG = 12;
	localparam int EVT_W = 3;
	localparam int BIT_POR = 0;
	localparam int BIT_BROWNOUT = 1;
	localparam int BIT_INSTR = 2;
	localparam int BIT_WDOG = 3;
	localparam int BIT_PIN = 4;
	localparam int BIT_LP_BROWNOUT = 5;
	localparam int BIT_TRAP = 6;
	localparam int BIT_ILL_OP = 7;
	localparam int BIT_UNINIT_WREG = 8;
	localparam int BIT_WDT_SW_EN = 9;
	localparam int BIT_SLEEP = 10;
	localparam int BIT_IDLE = 11;
	localparam logic [11:0] CAUSE_POR_VAL = 12'h003;
	localparam logic [11:0] CAUSE_SRC_MASK = 12'h1ff;
	// --------------------------------------------------------------
	// Interrupt events
	// --------------------------------------------------------------
	localparam int EVT_RELEASE = 0;
	localparam int EVT_SLEEP = 1;
	localparam int EVT_IDLE = 2;
	localparam logic [2:0] EVT_RST_VAL = 3'h0;
	localparam logic [2:0] MASK_RST_VAL = 3'h0;
	// --------------------------------------------------------------
	// Register map, byte addresses
	// --------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CAUSE = 8'h00;
	localparam logic [7:0] OFF_EVT = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_SCRATCH = 8'h0c;
	localparam logic [7:0] OFF_LIVE = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rsc_flag.sv ====
`timescale 1ns/1ps
// One reset cause or status flag
module rsc_flag #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic por_in,
	input wire logic set_in,
	input wire logic wr_in,
	input wire logic wr_val_in,
	output logic flag_out
);
	logic next_flag;

	// Power-on wins, then a live source, then software; a source that is
	// active in the cycle of a software clear keeps the flag set
	assign next_flag = por_in ? RST_VAL :
		(set_in | (wr_in ? wr_val_in : flag_out));

	// Flag update
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			flag_out <= RST_VAL;
		else if (ce_in)
			flag_out <= next_flag;
	end
endmodule

// ==== rsc_combiner.sv ====
`timescale 1ns/1ps
// Behaviour
// - Nine reset sources feed the master reset
// - Any active source asserts master reset
// - Master reset forces designated registers to defaults
// - Undefined registers keep contents through non-power-on resets
// - Each reset kind sets its own cause flag
// - Power-on leaves only power-on and brown-out flags
// - Software may set or clear any flag
// - Software-set flags never start a reset
// - Watchdog and power-saving bits sit beside causes
module rsc_combiner (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic power_on_reset_in,
	input wire logic external_pin_reset_in,
	input wire logic instruction_reset_in,
	input wire logic watchdog_reset_in,
	input wire logic brownout_reset_in,
	input wire logic low_power_brownout_reset_in,
	input wire logic trap_conflict_reset_in,
	input wire logic illegal_opcode_reset_in,
	input wire logic uninit_wreg_reset_in,
	input wire logic sleep_wake_in,
	input wire logic idle_wake_in,
	output logic master_system_reset_out,
	output logic wdt_sw_enable_out,
	output logic irq_out,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	// --------------------------------------------------------------
	// Functions
	// --------------------------------------------------------------
	// Byte-lane merge of a write into an old register value
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction

	// Address decode for the read response; the write path decodes its own offsets
	function automatic logic addr_known(input logic [7:0] a);
		return a == rsc_pkg::OFF_CAUSE || a == rsc_pkg::OFF_EVT ||
			a == rsc_pkg::OFF_MASK || a == rsc_pkg::OFF_SCRATCH ||
			a == rsc_pkg::OFF_LIVE;
	endfunction

	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	logic [8:0] src_vec;
	logic any_src;
	logic [11:0] flag_set;
	logic [11:0] cause;
	logic [2:0] evt;
	logic [2:0] mask;
	logic [2:0] next_evt;
	logic [2:0] evt_new;
	logic [31:0] scratch;
	logic sleep_q;
	logic idle_q;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_wr;
	logic rd_go;
	logic wr_cause;
	logic wr_mask;
	logic wr_scratch;
	logic rd_evt;
	logic [31:0] rd_mux;
	logic [31:0] mask_merged;
	logic scratch_known;

	// --------------------------------------------------------------
	// Reset combination
	// --------------------------------------------------------------
	// Source vector in cause-flag bit order
	assign src_vec = {uninit_wreg_reset_in, illegal_opcode_reset_in,
		trap_conflict_reset_in, low_power_brownout_reset_in,
		external_pin_reset_in, watchdog_reset_in, instruction_reset_in,
		brownout_reset_in, power_on_reset_in};
	// Only the source pins reach the master reset, never a flag
	assign any_src = |src_vec;

	// Registered so the reset tree sees a glitch-free level
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			master_system_reset_out <= 1'b1;
		else if (ce_in)
			master_system_reset_out <= any_src;
	end

	// --------------------------------------------------------------
	// Cause and status flags
	// --------------------------------------------------------------
	// Sources set causes; sleep and idle wakes set status bits
	assign flag_set = {idle_wake_in, sleep_wake_in, 1'b0, src_vec};

	generate
		for (genvar i = 0; i < rsc_pkg::NUM_FLAG; i++)
		begin : g_flag
			rsc_flag #(
				.RST_VAL(rsc_pkg::CAUSE_POR_VAL[i])
			) u_flag (
				.ref_clk_in(ref_clk_in),
				.rst_n_in(rst_n_in),
				.ce_in(ce_in),
				.por_in(power_on_reset_in),
				.set_in(flag_set[i]),
				.wr_in(wr_cause & w_strb_q[i/8]),
				.wr_val_in(w_data_q[i]),
				.flag_out(cause[i])
			);
		end
	endgenerate

	// Software-owned watchdog enable, not a reset cause
	assign wdt_sw_enable_out = cause[rsc_pkg::BIT_WDT_SW_EN];

	// --------------------------------------------------------------
	// Interrupt events
	// --------------------------------------------------------------
	// Release, sleep wake and idle wake edges
	assign evt_new = {idle_wake_in & ~idle_q, sleep_wake_in & ~sleep_q,
		master_system_reset_out & ~any_src};
	// New events win over the clear of a read in the same cycle
	assign next_evt = (rd_evt ? 3'h0 : evt) | evt_new;
	assign irq_out = |(evt & mask);

	// Event flags survive master reset so the release event is seen
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			evt <= rsc_pkg::EVT_RST_VAL;
			sleep_q <= 1'b0;
			idle_q <= 1'b0;
		end
		else if (ce_in)
		begin
			evt <= next_evt;
			sleep_q <= sleep_wake_in;
			idle_q <= idle_wake_in;
		end
	end

	// --------------------------------------------------------------
	// Software registers
	// --------------------------------------------------------------
	assign mask_merged = lane_merge({29'h0, mask}, w_data_q, w_strb_q);

	// Mask has a defined default and is forced by master reset
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in || (ce_in && master_system_reset_out))
			mask <= rsc_pkg::MASK_RST_VAL;
		else if (ce_in && wr_mask)
			mask <= mask_merged[2:0];
	end

	// Scratch has no reset value: unknown at power-up, kept otherwise
	always_ff @(posedge ref_clk_in)
	begin
		if (ce_in && wr_scratch)
			scratch <= lane_merge(scratch, w_data_q, w_strb_q);
	end

	// Scratch is unknown until first written, so its hold check waits
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			scratch_known <= 1'b0;
		else if (ce_in && wr_scratch)
			scratch_known <= 1'b1;
	end

	// --------------------------------------------------------------
	// AXI4-Lite write path
	// --------------------------------------------------------------
	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
	assign do_wr = aw_held && w_held && !s_axi_bvalid_out;
	assign wr_cause = do_wr && aw_addr_q == rsc_pkg::OFF_CAUSE;
	assign wr_mask = do_wr && aw_addr_q == rsc_pkg::OFF_MASK;
	assign wr_scratch = do_wr && aw_addr_q == rsc_pkg::OFF_SCRATCH;

	// Address and data may arrive in either order
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end
		else if (ce_in)
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr_in;
			end
			else if (do_wr)
				aw_held <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end
			else if (do_wr)
				w_held <= 1'b0;
		end
	end

	// Write response; read-only and unmapped words answer SLVERR
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= rsc_pkg::RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (do_wr)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (wr_cause || wr_mask || wr_scratch) ?
					rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// AXI4-Lite read path
	// --------------------------------------------------------------
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
	// Clear-on-read of the event word happens at the taking edge
	assign rd_evt = rd_go && s_axi_araddr_in == rsc_pkg::OFF_EVT;
	assign rd_mux =
		(s_axi_araddr_in == rsc_pkg::OFF_CAUSE) ? {20'h0, cause} :
		(s_axi_araddr_in == rsc_pkg::OFF_EVT) ? {29'h0, evt} :
		(s_axi_araddr_in == rsc_pkg::OFF_MASK) ? {29'h0, mask} :
		(s_axi_araddr_in == rsc_pkg::OFF_SCRATCH) ? scratch :
		(s_axi_araddr_in == rsc_pkg::OFF_LIVE) ? {23'h0, src_vec} :
		32'h0;

	// Read data is captured once and held until rready
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= rsc_pkg::RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (rd_go)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_mux;
				s_axi_rresp_out <= addr_known(s_axi_araddr_in) ?
					rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Master reset follows the OR of exactly the nine sources
	AST_MASTER_IS_OR: assert property (
		ce_in |=> master_system_reset_out == $past(|src_vec))
		else $error("master reset is not the OR of the sources");

	// A source held two cycles keeps master reset up for the second
	AST_SRC_HOLDS: assert property (
		(ce_in && any_src) [*2] |-> master_system_reset_out)
		else $error("active source did not assert master reset");

	AST_MASK_FORCED: assert property (
		ce_in && master_system_reset_out |=> mask == rsc_pkg::MASK_RST_VAL)
		else $error("mask not forced by master reset");

	AST_SCRATCH_KEPT: assert property (
		scratch_known && !wr_scratch |=> $stable(scratch))
		else $error("scratch changed without a write");

	AST_CAUSE_SET: assert property (
		ce_in && !power_on_reset_in |=>
		(cause[8:0] & $past(src_vec)) == $past(src_vec))
		else $error("active source left its cause flag clear");

	AST_POR_VALUE: assert property (
		ce_in && power_on_reset_in |=> cause == rsc_pkg::CAUSE_POR_VAL)
		else $error("power-on did not leave only bits 1:0");

	AST_SW_WRITE: assert property (
		ce_in && wr_cause && w_strb_q[0] && !any_src && !sleep_wake_in
		&& !idle_wake_in |=> cause[7:0] == $past(w_data_q[7:0]))
		else $error("software write to cause flags lost");

	AST_SW_NO_RESET: assert property (
		ce_in && wr_cause && !any_src ##1 ce_in && !any_src
		|=> !master_system_reset_out)
		else $error("software flag write started a reset");

	AST_WDT_EN_SW_ONLY: assert property (
		ce_in && !wr_cause && !power_on_reset_in |=>
		$stable(wdt_sw_enable_out))
		else $error("watchdog enable moved without software");

	AST_CAUSE_HOLDS: assert property (
		ce_in && !wr_cause && !any_src |=> $stable(cause[8:0]))
		else $error("cause flags changed with no source or write");

	AST_IRQ_LEVEL: assert property (
		ce_in && |(evt_new & mask) && !master_system_reset_out && !wr_mask
		|=> irq_out)
		else $error("interrupt output disagrees with status and mask");

	COV_POR: cover property (power_on_reset_in ##1 !any_src [*2]);
	COV_WDOG_CLEAR: cover property (watchdog_reset_in ##[1:20] wr_cause);
	COV_IRQ_READ: cover property (irq_out ##[1:20] rd_evt);
	COV_SLVERR: cover property (s_axi_bvalid_out && s_axi_bresp_out[1]);
endmodule

// ==== rsc_combiner_tb_top.sv ====
`timescale 1ns/1ps
module rsc_combiner_tb_top;
	// ----------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------
	logic clk = 1'b0, rst_n = 1'b0, slp = 1'b0, idl = 1'b0, ce = 1'b1;
	logic [8:0] src = 9'h000;
	logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] strb = 4'hf;
	logic mst, wen, irq, awr, wr_rdy, bv, arr, rv;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, d;
	int mismatches = 0, check_count = 0;

	rsc_combiner dut_u (
		.ref_clk_in(clk),
		.rst_n_in(rst_n),
		.ce_in(ce),
		.power_on_reset_in(src[0]),
		.brownout_reset_in(src[1]),
		.instruction_reset_in(src[2]),
		.watchdog_reset_in(src[3]),
		.external_pin_reset_in(src[4]),
		.low_power_brownout_reset_in(src[5]),
		.trap_conflict_reset_in(src[6]),
		.illegal_opcode_reset_in(src[7]),
		.uninit_wreg_reset_in(src[8]),
		.sleep_wake_in(slp),
		.idle_wake_in(idl),
		.master_system_reset_out(mst),
		.wdt_sw_enable_out(wen),
		.irq_out(irq),
		.s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr),
		.s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(strb),
		.s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr_rdy),
		.s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv),
		.s_axi_bready_in(brdy),
		.s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr),
		.s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv),
		.s_axi_rready_in(rrdy)
	);

	// 100 ns clock
	initial
	begin
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------
	// Compare and closing tasks
	// ----------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic s);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %s expected %b seen %b", nm, e, s);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole run is under a thousand cycles; twenty thousand is ample
	initial
	begin
		#(100 * 20000);
		mismatches++;
		results();
	end

	// ----------------------------------------------------------
	// Bus tasks, entered and left just after a rising edge
	// ----------------------------------------------------------
	// Handshakes are judged at the rising edge on pre-edge values; only
	// the watchdog ends a wait that never completes
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s);
		bit ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= v;
		strb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge clk);
			if (!ad && awr)
			begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (!wd && wr_rdy)
			begin
				wd = 1'b1;
				wv <= 1'b0;
			end
		end
		do
		begin
			@(posedge clk);
		end while (bv !== 1'b1);
		rsp = bresp;
		brdy <= 1'b0;
		// Extra edge so the next call never drives bready twice at once
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do
		begin
			@(posedge clk);
		end while (arr !== 1'b1);
		arv <= 1'b0;
		do
		begin
			@(posedge clk);
		end while (rv !== 1'b1);
		d = rdata;
		rsp = rresp;
		rrdy <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, d);
	endtask

	// Expected cause flags after the given sources held reset
	function automatic logic [31:0] exp_cause(input logic [8:0] m);
		return m[0] ? {20'h0, rsc_pkg::CAUSE_POR_VAL} : {23'h0, m};
	endfunction

	// Hold sources three edges, then release and let master fall
	task automatic pulse(input logic [8:0] m);
		src <= m;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chkb("master high", 1'b1, mst);
		@(posedge clk);
		src <= 9'h000;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chkb("master low", 1'b0, mst);
		@(posedge clk);
	endtask

	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial
	begin
		logic [8:0] m;
		logic [11:0] v;
		logic [31:0] w;
		int seed;
		seed = $urandom(32'h7dbb);
		@(posedge clk);
		@(negedge clk);
		chkb("master in reset", 1'b1, mst);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc("cause", rsc_pkg::OFF_CAUSE, 32'h003);
		rc("mask", rsc_pkg::OFF_MASK, 32'h0);
		rc("event", rsc_pkg::OFF_EVT, 32'h1);
		rc("event cleared", rsc_pkg::OFF_EVT, 32'h0);
		$display("test reset done");
		// Every source alone, then random mixtures
		for (int i = 0; i < 12; i++)
		begin
			m = (i < 9) ? 9'h001 << i : 9'($urandom);
			// An all-quiet mixture would prove nothing about the OR
			if (m == 9'h000)
				m = 9'h080;
			wr(rsc_pkg::OFF_CAUSE, 32'h0, 4'hf);
			pulse(m);
			rc("cause", rsc_pkg::OFF_CAUSE, exp_cause(m));
		end
		$display("test sources done");
		// Scratch survives a watchdog reset, mask is forced clear
		w = $urandom;
		wr(rsc_pkg::OFF_SCRATCH, w, 4'hf);
		wr(rsc_pkg::OFF_MASK, 32'h7, 4'hf);
		pulse(9'h008);
		rc("scratch", rsc_pkg::OFF_SCRATCH, w);
		rc("mask", rsc_pkg::OFF_MASK, 32'h0);
		rd(rsc_pkg::OFF_EVT);
		$display("test retention done");
		// Software writes of the cause flags, full and lane 0 only
		repeat (4)
		begin
			v = 12'($urandom);
			wr(rsc_pkg::OFF_CAUSE, {20'h0, v}, 4'hf);
			@(negedge clk);
			chkb("master quiet", 1'b0, mst);
			chkb("wdt enable", v[9], wen);
			@(posedge clk);
			rc("cause", rsc_pkg::OFF_CAUSE, {20'h0, v});
			w = $urandom;
			wr(rsc_pkg::OFF_CAUSE, w, 4'h1);
			rc("cause", rsc_pkg::OFF_CAUSE, {20'h0, v[11:8], w[7:0]});
		end
		wr(rsc_pkg::OFF_CAUSE, 32'h0, 4'hf);
		$display("test software done");
		// Wake events, unmasked then masked
		wr(rsc_pkg::OFF_MASK, 32'h6, 4'hf);
		slp <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chkb("irq", 1'b1, irq);
		@(posedge clk);
		rc("event", rsc_pkg::OFF_EVT, 32'h2);
		@(negedge clk);
		chkb("irq cleared", 1'b0, irq);
		@(posedge clk);
		slp <= 1'b0;
		wr(rsc_pkg::OFF_MASK, 32'h0, 4'hf);
		idl <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chkb("irq masked", 1'b0, irq);
		@(posedge clk);
		rc("event", rsc_pkg::OFF_EVT, 32'h4);
		rc("cause", rsc_pkg::OFF_CAUSE, 32'hc00);
		idl <= 1'b0;
		$display("test interrupt done");
		// Refused accesses
		rc("unmapped data", 8'h20, 32'h0);
		chk("unmapped rresp", {30'h0, rsc_pkg::RESP_SLVERR}, {30'h0, rsp});
		wr(rsc_pkg::OFF_EVT, 32'h7, 4'hf);
		chk("ro bresp", {30'h0, rsc_pkg::RESP_SLVERR}, {30'h0, rsp});
		$display("test errors done");
		// Clock enable low freezes master reset and the cause flags
		ce <= 1'b0;
		src <= 9'h004;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chkb("frozen master", 1'b0, mst);
		@(posedge clk);
		src <= 9'h000;
		ce <= 1'b1;
		@(posedge clk);
		rc("frozen cause", rsc_pkg::OFF_CAUSE, 32'hc00);
		$display("test enable done");
		// Second power-on in mid-run
		wr(rsc_pkg::OFF_CAUSE, 32'h1f0, 4'hf);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc("cause", rsc_pkg::OFF_CAUSE, 32'h003);
		$display("test power-on done");
		results();
	end
endmodule
